/* src/dprc_ctrl.sv */
// Host-side strobe controller for a 16K x 1 multiplexed-address dynamic RAM.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Only early writes; shared data line stays safe
// - Select devices by decoding row/column strobes; the controller drives a single ras_n/cas_n pair with no decode
// - Page burst holds row strobe low
// - Wide page: common row, decoded column; the controller drives one device, so page mode only reuses the open row
// - Every row cycled within 2 ms
// - Refresh with row-strobe-only cycles
// - Eight refresh cycles after power-up
// - Supply fault forces both strobes high
// - Cycle 410 ns, sample after 250 ns
// - Row then column address on 7 lines
// - Write before column strobe: early write
// - Data taken at later falling edge
// - Reads keep write command high
module dprc_ctrl
    import dprc_pkg::*;
#(
    parameter int REF_INTERVAL = C_REF
) (
    input  wire logic                       clock,
    input  wire logic                       nrst,
    input  wire dprc_pkg::dprc_req_t        req,
    input  wire logic                       supply_fault,
    input  wire logic                       mem_data_out,
    output logic                            req_ready,
    output logic                            rd_valid,
    output logic                            rd_data,
    output logic                            warm_done,
    output dprc_pkg::dprc_pins_t            pins
);
    import dprc_pkg::*;

    // Too short leaves no room for a refresh cycle; too long misses the retention period.
    if (REF_INTERVAL < C_RC + C_RP + 2 || REF_INTERVAL > C_REF) begin : gen_bad_interval
        $error("REF_INTERVAL outside the range the refresh pacing can serve");
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin input synchroniser: three flops, a change counts when two agree.
    logic sync1;
    logic sync2;
    logic sync3;
    logic din_filt;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
        end else begin
            sync1 <= mem_data_out;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            din_filt <= 1'b0;
        end else if (sync2 == sync3) begin
            din_filt <= sync3;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    dprc_state_t            state;
    logic [15:0]            tcnt;
    logic [15:0]            ras_cnt;
    localparam int          REF_W = $clog2(REF_INTERVAL + 1);
    logic [REF_W-1:0]       ref_timer;
    logic                   long_pre;
    logic                   ref_due;
    logic [ROW_BITS-1:0]    ref_row;
    logic [3:0]             warm_cnt;
    logic [ROW_BITS-1:0]    open_row;
    logic                   cur_write;
    logic                   cur_keep;
    logic [COL_BITS-1:0]    cur_col;
    logic                   cur_wdata;

    // Refresh pacing: one row every REF_INTERVAL cycles covers all 128 rows in 2 ms.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ref_timer <= '0;
            ref_due   <= 1'b0;
        end else begin
            if (ref_timer >= REF_W'(REF_INTERVAL - 1)) begin
                ref_timer <= '0;
                ref_due   <= 1'b1;
            end else begin
                ref_timer <= ref_timer + 1'b1;
                if (state == ST_REFRESH && tcnt == 16'h0000) begin
                    ref_due <= 1'b0;
                end
            end
        end
    end

    // Refresh row counter wraps from the last row to the first.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ref_row  <= '0;
            warm_cnt <= '0;
        end else if (state == ST_REFRESH && tcnt == 16'(C_RC - C_RP - 1)) begin
            ref_row <= ref_row + 1'b1;
            if (warm_cnt != 4'(WARMUP_CYCLES)) begin
                warm_cnt <= warm_cnt + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state     <= ST_WARM;
            tcnt      <= '0;
            long_pre  <= 1'b0;
            ras_cnt   <= '0;
            open_row  <= '0;
            cur_write <= 1'b0;
            cur_keep  <= 1'b0;
            cur_col   <= '0;
            cur_wdata <= 1'b0;
            req_ready <= 1'b0;
            rd_valid  <= 1'b0;
            rd_data   <= 1'b0;
            warm_done <= 1'b0;
            pins      <= '{ras_n: 1'b1, cas_n: 1'b1, write_n: 1'b1,
                           mux_address_in: '0, data_in: 1'b0};
        end else begin
            rd_valid  <= 1'b0;
            req_ready <= 1'b0;
            warm_done <= (warm_cnt == 4'(WARMUP_CYCLES));
            ras_cnt   <= pins.ras_n ? 16'h0000 : ras_cnt + 1'b1;
            if (supply_fault) begin
                // A faulted supply leaves the array safest with both strobes idle.
                pins.ras_n   <= 1'b1;
                pins.cas_n   <= 1'b1;
                pins.write_n <= 1'b1;
                state        <= ST_PRE;
                tcnt         <= '0;
                long_pre     <= 1'b1;
            end else begin
                case (state)
                ST_WARM, ST_IDLE: begin
                    tcnt <= '0;
                    if (state == ST_WARM || ref_due) begin
                        if (state == ST_WARM && warm_cnt == 4'(WARMUP_CYCLES)) begin
                            state <= ST_IDLE;
                        end else begin
                            // Row-strobe-only cycle, column strobe held high.
                            pins.mux_address_in <= ref_row;
                            state               <= ST_REFRESH;
                        end
                    end else if (req.valid) begin
                        cur_write           <= req.write;
                        cur_keep            <= req.keep_page;
                        cur_col             <= req.col;
                        cur_wdata           <= req.wdata;
                        open_row            <= req.row;
                        pins.mux_address_in <= req.row;
                        state               <= ST_RAS;
                    end else begin
                        req_ready <= (state == ST_IDLE);
                    end
                end
                ST_REFRESH: begin
                    pins.ras_n <= 1'b0;
                    tcnt       <= tcnt + 1'b1;
                    if (tcnt == 16'(C_RC - C_RP - 1)) begin
                        pins.ras_n <= 1'b1;
                        tcnt       <= '0;
                        state      <= ST_PRE;
                    end
                end
                ST_RAS: begin
                    // One strobe pair per controller; array selection decodes them outside.
                    pins.ras_n <= 1'b0;
                    tcnt       <= tcnt + 1'b1;
                    if (tcnt == 16'(C_RCD)) begin
                        pins.mux_address_in <= cur_col;
                        // Write command falls before the column strobe.
                        pins.write_n <= ~cur_write;
                        pins.data_in <= cur_wdata;
                        tcnt         <= '0;
                        state        <= ST_CAS;
                    end
                end
                ST_CAS: begin
                    pins.cas_n <= 1'b0;
                    tcnt       <= tcnt + 1'b1;
                    // Sample only once the row access time has also elapsed.
                    if (tcnt >= 16'(C_CAS) && ras_cnt >= 16'(C_RAC + 3)) begin
                        if (!cur_write) begin
                            rd_valid <= 1'b1;
                            rd_data  <= din_filt;
                        end
                        pins.cas_n   <= 1'b1;
                        pins.write_n <= 1'b1;
                        tcnt         <= '0;
                        state        <= ST_CASPRE;
                    end
                end
                ST_CASPRE: begin
                    tcnt <= tcnt + 1'b1;
                    if (tcnt >= 16'(C_CP)) begin
                        if (cur_keep && req.valid && !ref_due && req.row == open_row) begin
                            // Same row: new column without a fresh row strobe.
                            cur_write           <= req.write;
                            cur_keep            <= req.keep_page;
                            cur_wdata           <= req.wdata;
                            pins.mux_address_in <= req.col;
                            pins.write_n        <= ~req.write;
                            pins.data_in        <= req.wdata;
                            tcnt                <= '0;
                            state               <= ST_CAS;
                        end else if (ras_cnt >= 16'(C_RC - C_RP)) begin
                            pins.ras_n <= 1'b1;
                            tcnt       <= '0;
                            state      <= ST_PRE;
                        end
                    end
                end
                ST_PRE: begin
                    tcnt <= tcnt + 1'b1;
                    // An aborted cycle may have cut the row strobe short, so wait a full cycle.
                    if (tcnt >= (long_pre ? 16'(C_RC) : 16'(C_RP))) begin
                        tcnt     <= '0;
                        long_pre <= 1'b0;
                        state    <= (warm_cnt == 4'(WARMUP_CYCLES)) ? ST_IDLE : ST_WARM;
                    end
                end
                default: begin
                    state <= ST_WARM;
                end
                endcase
            end
        end
    end
endmodule : dprc_ctrl
`default_nettype wire

/* src/dprc_pkg.sv */
// Package with timing constants, states and carrier structs for the page/refresh controller.
package dprc_pkg;
    localparam int CLK_MHZ          = 200;
    localparam int ROW_BITS         = 7;
    localparam int COL_BITS         = 7;
    localparam int ROW_COUNT        = 128;
    // Times in ns (refresh period in ms); cycle counts derived at 200 MHz.
    localparam int T_RC_NS          = 410;
    localparam int T_RAC_NS         = 250;
    localparam int T_RP_NS          = 150;
    localparam int T_RCD_NS         = 35;
    localparam int T_CAS_NS         = 165;
    localparam int T_CP_NS          = 100;
    localparam int T_WCH_NS         = 75;
    localparam int T_REF_MS         = 2;
    localparam int WARMUP_CYCLES    = 8;
    localparam int C_RC   = (T_RC_NS * CLK_MHZ + 999) / 1000;
    localparam int C_RAC  = (T_RAC_NS * CLK_MHZ + 999) / 1000;
    localparam int C_RP   = (T_RP_NS * CLK_MHZ + 999) / 1000;
    localparam int C_RCD  = (T_RCD_NS * CLK_MHZ + 999) / 1000;
    localparam int C_CAS  = (T_CAS_NS * CLK_MHZ + 999) / 1000;
    localparam int C_CP   = (T_CP_NS * CLK_MHZ + 999) / 1000;
    localparam int C_WCH  = (T_WCH_NS * CLK_MHZ + 999) / 1000;
    // Longest time: rounds down. Spread over all rows.
    localparam int C_REF  = (T_REF_MS * 1000 * CLK_MHZ) / ROW_COUNT;

    typedef enum {
        ST_WARM, ST_IDLE, ST_RAS, ST_CAS, ST_CASPRE, ST_REFRESH, ST_PRE
    } dprc_state_t;

    // Request from the user side.
    typedef struct packed {
        logic                valid;
        logic                write;
        logic                keep_page;
        logic [ROW_BITS-1:0] row;
        logic [COL_BITS-1:0] col;
        logic                wdata;
    } dprc_req_t;

    // Pins toward the memory (strobes active low).
    typedef struct packed {
        logic                ras_n;
        logic                cas_n;
        logic                write_n;
        logic [ROW_BITS-1:0] mux_address_in;
        logic                data_in;
    } dprc_pins_t;
endpackage : dprc_pkg

/* tb/dprc_ctrl_asserts.sv */
// Strobe timing checker bound to the page/refresh controller.
`timescale 1ns/1ps
`default_nettype none
module dprc_ctrl_asserts #(
    parameter int REF_INTERVAL = dprc_pkg::C_REF
) (
    input  wire logic                 clock,
    input  wire logic                 nrst,
    input  wire logic                 supply_fault,
    input  wire logic                 rd_valid,
    input  wire logic                 warm_done,
    input  wire dprc_pkg::dprc_pins_t pins
);
    import dprc_pkg::*;
    int since_fall;
    int low_len;
    int falls;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) since_fall <= C_RC;
        else if ($fell(pins.ras_n)) since_fall <= 1;
        else since_fall <= since_fall + 1;
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) low_len <= 0;
        else if (pins.ras_n) low_len <= 0;
        else low_len <= low_len + 1;
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) falls <= 0;
        else if ($fell(pins.ras_n) && falls < 15) falls <= falls + 1;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence cas_fall_s;
        $fell(pins.cas_n);
    endsequence
    fault_strobes_high_a: assert property (supply_fault |-> ##[0:2] (pins.ras_n && pins.cas_n))
        else $error("strobes not released on fault");
    cas_within_ras_a: assert property (cas_fall_s |-> !pins.ras_n)
        else $error("column strobe without row strobe");
    early_write_setup_a: assert property (cas_fall_s |-> $stable(pins.write_n) && $stable(pins.data_in))
        else $error("write command or data moved at column strobe");
    cas_low_steady_a: assert property (!pins.cas_n && !$past(pins.cas_n) |-> $stable(pins.write_n) && $stable(pins.mux_address_in))
        else $error("command or address moved while column strobe low");
    warm_ras_only_a: assert property (!warm_done && !pins.ras_n |-> pins.cas_n)
        else $error("column strobe during warm-up");
    row_cycle_time_a: assert property ($fell(pins.ras_n) |-> since_fall >= C_RC)
        else $error("row cycle shorter than minimum");
    read_access_time_a: assert property (rd_valid |-> low_len >= C_RAC)
        else $error("read sampled before access time");
    warm_count_a: assert property ($rose(warm_done) |-> falls >= WARMUP_CYCLES)
        else $error("warm-up ended too early");
    refresh_gap_a: assert property (since_fall <= REF_INTERVAL + 4 * C_RC)
        else $error("refresh interval exceeded");
endmodule : dprc_ctrl_asserts
bind dprc_ctrl dprc_ctrl_asserts #(.REF_INTERVAL(REF_INTERVAL)) dprc_ctrl_asserts_i (
    .clock(clock), .nrst(nrst), .supply_fault(supply_fault),
    .rd_valid(rd_valid), .warm_done(warm_done), .pins(pins));
`default_nettype wire

/* tb/dprc_mem_model.sv */
// Behavioural 16K x 1 multiplexed-address memory that answers the controller's strobes.
`timescale 1ns/1ps
`default_nettype none
module dprc_mem_model (
    input  wire logic       ras_n,
    input  wire logic       cas_n,
    input  wire logic       write_n,
    input  wire logic [6:0] mux_address_in,
    input  wire logic       data_in,
    output logic            data_out
);
    logic       mem [0:16383];
    logic [6:0] row;
    logic [6:0] col;
    logic       q = 1'b0;
    logic       drive = 1'b0;
    // A falling row strobe alone refreshes the row; the column strobe is ignored without it.
    always @(negedge ras_n) row = mux_address_in;
    always @(negedge cas_n) begin
        if (!ras_n) begin
            col = mux_address_in;
            drive = write_n;
            if (!write_n) mem[{row, col}] = data_in;
            q = mem[{row, col}];
        end
    end
    always @(posedge cas_n) drive = 1'b0;
    // An undriven output shows the inverse so a stale sample cannot pass.
    assign data_out = (drive && !cas_n) ? q : ~q;
endmodule : dprc_mem_model
`default_nettype wire

/* tb/tb_dprc_ctrl.sv */
// Self-checking bench for the page/refresh controller with a behavioural memory.
`timescale 1ns/1ps
`default_nettype none
module tb_dprc_ctrl;
    import dprc_pkg::*;
    localparam int REF_IV = 600;
    logic       clock = 1'b0;
    logic       nrst = 1'b0;
    dprc_req_t  req = '0;
    logic       supply_fault = 1'b0;
    logic       mem_data_out;
    logic       req_ready;
    logic       rd_valid;
    logic       rd_data;
    logic       warm_done;
    dprc_pins_t pins;
    int         mismatches = 0;
    int         tests_run = 0;
    int         cycles = 0;
    int         ras_falls = 0;
    int         cas_falls = 0;
    int         r0;
    int         c0;
    logic [6:0] a0;
    initial forever #2.5 clock = ~clock;
    always @(negedge pins.ras_n) ras_falls++;
    always @(negedge pins.cas_n) cas_falls++;
    dprc_ctrl #(.REF_INTERVAL(REF_IV)) dprc_ctrl_i (.clock(clock), .nrst(nrst), .req(req),
        .supply_fault(supply_fault), .mem_data_out(mem_data_out), .req_ready(req_ready),
        .rd_valid(rd_valid), .rd_data(rd_data), .warm_done(warm_done), .pins(pins));
    dprc_mem_model dprc_mem_model_i (.ras_n(pins.ras_n), .cas_n(pins.cas_n),
        .write_n(pins.write_n), .mux_address_in(pins.mux_address_in),
        .data_in(pins.data_in), .data_out(mem_data_out));
    task automatic chk(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask : chk
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            give_verdict();
        end
    end
    // The falling column strobe after the request is raised shows the request was taken.
    task automatic access(input logic wr, input logic keep, input logic [6:0] row,
                          input logic [6:0] col, input logic d);
        int n;
        n = 0;
        @(negedge clock);
        req = '{valid: 1'b1, write: wr, keep_page: keep, row: row, col: col, wdata: d};
        while (pins.cas_n !== 1'b1 && n < 400) begin
            @(negedge clock);
            n++;
        end
        while (pins.cas_n !== 1'b0 && n < 400) begin
            @(negedge clock);
            n++;
        end
        req.valid = 1'b0;
        chk("req_ready busy", 1'b0, req_ready);
        while (!wr && rd_valid !== 1'b1 && n < 400) begin
            @(negedge clock);
            n++;
        end
        chk("handshake", 1'b1, n < 400);
        if (!wr) chk("rd_data", d, rd_data);
    endtask : access
    task automatic t_warm;
        repeat (3000) if (warm_done !== 1'b1) @(negedge clock);
        chk("warm_done", 1'b1, warm_done);
        chk("warm ras_falls", 1'b1, ras_falls >= 8);
    endtask : t_warm
    task automatic t_rw;
        access(1'b1, 1'b0, 7'h00, 7'h00, 1'b1);
        access(1'b1, 1'b0, 7'h01, 7'h00, 1'b0);
        access(1'b0, 1'b0, 7'h00, 7'h00, 1'b1);
        access(1'b0, 1'b0, 7'h01, 7'h00, 1'b0);
    endtask : t_rw
    task automatic t_page;
        // Start right after a refresh so that none falls due inside the burst.
        @(negedge pins.ras_n);
        @(negedge clock);
        r0 = ras_falls;
        access(1'b1, 1'b1, 7'h7F, 7'h00, 1'b1);
        access(1'b1, 1'b1, 7'h7F, 7'h7F, 1'b0);
        access(1'b0, 1'b1, 7'h7F, 7'h00, 1'b1);
        access(1'b0, 1'b0, 7'h7F, 7'h7F, 1'b0);
        chk("page ras_falls", 1'b1, ras_falls - r0 < 3);
    endtask : t_page
    task automatic t_refresh;
        repeat (10) @(negedge clock);
        repeat (200) if (req_ready !== 1'b1) @(negedge clock);
        chk("req_ready idle", 1'b1, req_ready);
        r0 = ras_falls;
        c0 = cas_falls;
        repeat (3 * REF_IV) @(negedge clock);
        chk("refresh count", 1'b1, ras_falls - r0 >= 2);
        chk("refresh cas", 1'b1, cas_falls == c0);
        @(negedge pins.ras_n);
        a0 = pins.mux_address_in;
        @(negedge pins.ras_n);
        chk("refresh row step", 1'b1, pins.mux_address_in == a0 + 7'h01);
        access(1'b0, 1'b0, 7'h00, 7'h00, 1'b1);
    endtask : t_refresh
    task automatic t_fault;
        @(negedge clock);
        req = '{valid: 1'b1, write: 1'b0, keep_page: 1'b0, row: 7'h01, col: 7'h00, wdata: 1'b0};
        repeat (400) if (pins.cas_n !== 1'b0) @(negedge clock);
        req.valid = 1'b0;
        supply_fault = 1'b1;
        repeat (3) @(negedge clock);
        chk("fault ras_n", 1'b1, pins.ras_n);
        chk("fault cas_n", 1'b1, pins.cas_n);
        repeat (10) @(negedge clock);
        supply_fault = 1'b0;
        repeat (200) @(negedge clock);
        access(1'b0, 1'b0, 7'h7F, 7'h00, 1'b1);
    endtask : t_fault
    initial begin
        repeat (2) @(negedge clock);
        nrst = 1'b1;
        t_warm();
        t_rw();
        t_page();
        t_refresh();
        t_fault();
        give_verdict();
    end
endmodule : tb_dprc_ctrl
`default_nettype wire
